// *** rtl/trip_voter_map.svh ***
// register offsets, field positions, sizes and timing figures of the division trip voter
// assumes a 20 MHz mclk and a byte-addressed register port with 32-bit words
`ifndef TRIP_VOTER_MAP_SVH
`define TRIP_VOTER_MAP_SVH

`define TV_NDIV            4
`define TV_NVAR            8
`define TV_NUNIT           9
`define TV_ADDR_W          8

`define TV_REG_STATUS      8'h00
`define TV_REG_CLEAR       8'h04
`define TV_REG_ENABLE      8'h08
`define TV_REG_STATE       8'h0c
`define TV_REG_TEST        8'h10
`define TV_REG_PARTIAL     8'h14

`define TV_NEVT            4
`define TV_EVT_AUTO        0
`define TV_EVT_MANUAL      1
`define TV_EVT_REFUSED     2
`define TV_EVT_RESET       3

`define TV_TEST_INJ        0
`define TV_TEST_OUT        1
`define TV_TEST_DIV_LO     2
`define TV_TEST_DIV_HI     3
`define TV_TEST_VAR_LO     4
`define TV_TEST_VAR_HI     7

`define TV_CLK_KHZ         20000
`define TV_RESET_DELAY_MS  3000

`endif

// *** rtl/trip_voter_pkg.sv ***
// types shared by the division trip voter
// assumes trip_voter_map.svh for all sizes
`include "trip_voter_map.svh"

package trip_voter_pkg;

    // pin inputs, all fail-safe: a low level means trip or no bypass
    typedef struct packed {
        logic [`TV_NVAR-1:0][`TV_NDIV-1:0] var_ok;
        logic [`TV_NDIV-1:0]               nm_ok;
        logic [`TV_NDIV-1:0]               div_ok_a;
        logic [`TV_NDIV-1:0]               div_ok_b;
        logic                              man_ok_a;
        logic                              man_ok_b;
        logic                              mode_run_ok;
        logic                              reset_sw;
        logic [`TV_NDIV-1:0]               snsr_byp_req;
        logic [`TV_NDIV-1:0]               cu_byp_req;
    } pins_t;

    // drive outputs, high means energised or conducting
    typedef struct packed {
        logic load_drive_on;
        logic backup_coil_on;
        logic air_dump_on;
        logic rod_runin;
        logic reset_permit;
    } drives_t;

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b00,
        ST_TRIPPED = 2'b01,
        ST_PERMIT  = 2'b10
    } seal_state_t;

endpackage

// *** rtl/vote_count.sv ***
// one coincidence check: two or more of the unmasked divisions in trip
// assumes mask has at most one bit set, so four inputs vote 2oo4 and three vote 2oo3
`timescale 1ns/1ps

module vote_count
(
    // division trip states and bypass mask
    input  wire logic [3:0] trip,
    input  wire logic [3:0] mask,
    // coincidence result
    output logic            vote
);
    logic [3:0] live;
    logic [2:0] cnt;

    always_comb
    begin
        live = trip & ~mask;
        cnt  = 3'({2'b00, live[0]}) + 3'({2'b00, live[1]})
             + 3'({2'b00, live[2]}) + 3'({2'b00, live[3]});
        vote = (cnt >= 3'h2);
    end
endmodule

// *** rtl/division_trip_voter.sv ***
// one division of the four-division protection trip logic: coincidence, bypass, output
// assumes all pin inputs are asynchronous and fail-safe (low = trip or no bypass), single clock mclk
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "trip_voter_map.svh"

module division_trip_voter
#(
    parameter int unsigned DIV_ID          = 0,
    parameter int unsigned RESET_DELAY_CYC = `TV_RESET_DELAY_MS * `TV_CLK_KHZ
)
(
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst,
    // register port
    input  wire logic [`TV_ADDR_W-1:0]             addr,
    input  wire logic [31:0]                       wdata,
    input  wire logic                              wr,
    input  wire logic                              rd,
    output logic [31:0]                            rdata,
    output logic                                   irq,
    // field pins
    input  wire trip_voter_pkg::pins_t             pins,
    // drives and scram votes
    output trip_voter_pkg::drives_t                drives,
    output logic                                   scram_a,
    output logic                                   scram_b
);
    trip_voter_pkg::pins_t       sync1_q;
    trip_voter_pkg::pins_t       sync2_q;
    logic                        reset_sw_q;
    logic [`TV_NDIV-1:0]         snsr_byp_q;
    logic [`TV_NDIV-1:0]         cu_byp_q;
    logic                        refused;
    logic [`TV_NUNIT-1:0]        unit_vote;
    logic [`TV_NUNIT-1:0]        unit_part;
    logic [`TV_NDIV-1:0]         unit_trip [`TV_NUNIT];
    logic [`TV_NDIV-1:0]         inj_mask;
    logic                        auto_act;
    logic                        man_act;
    logic                        auto_q;
    logic                        man_q;
    logic                        div_trip;
    logic                        full_scram;
    trip_voter_pkg::seal_state_t seal_q;
    logic [31:0]                 dly_q;
    logic                        dly_done;
    logic                        reset_req;
    logic                        reset_take;
    logic [7:0]                  test_q;
    logic [`TV_NEVT-1:0]         evt;
    logic [`TV_NEVT-1:0]         stat_q;
    logic [`TV_NEVT-1:0]         en_q;
    logic                        auto_prev_q;
    logic                        man_prev_q;
    logic                        clr_wr;
    trip_voter_pkg::drives_t     drives_q;

    // two-stage synchroniser on every pin; reset value is all-trip, no-bypass
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reset_sw_q <= 1'b0;
        else
            reset_sw_q <= sync2_q.reset_sw;
    end

    // a request is taken only from no bypass to exactly one, and an all-zero request releases the bypass;
    // any other change keeps the present bypass and flags a refusal
    function automatic logic [`TV_NDIV-1:0] byp_next(input logic [`TV_NDIV-1:0] cur,
                                                   input logic [`TV_NDIV-1:0] req);
        logic [`TV_NDIV-1:0] nxt;
        nxt = cur;
        if (req == '0)
            nxt = '0;
        else if (cur == '0 && $onehot(req))
            nxt = req;
        return nxt;
    endfunction

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            snsr_byp_q <= '0;
            cu_byp_q   <= '0;
        end
        else
        begin
            snsr_byp_q <= byp_next(snsr_byp_q, sync2_q.snsr_byp_req);
            cu_byp_q   <= byp_next(cu_byp_q, sync2_q.cu_byp_req);
        end
    end

    // a second request while one is held, or a multi-bit request, counts as refused
    assign refused = (!$onehot0(sync2_q.snsr_byp_req) || !$onehot0(sync2_q.cu_byp_req)
                     || (snsr_byp_q != '0 && sync2_q.snsr_byp_req != '0
                         && sync2_q.snsr_byp_req != snsr_byp_q)
                     || (cu_byp_q != '0 && sync2_q.cu_byp_req != '0
                         && sync2_q.cu_byp_req != cu_byp_q));

    // test injection forces one chosen division of one chosen variable to trip; one
    // division alone never reaches coincidence, so the test cannot scram by itself
    always_comb
    begin
        inj_mask = '0;
        if (test_q[`TV_TEST_INJ])
            inj_mask[test_q[`TV_TEST_DIV_HI:`TV_TEST_DIV_LO]] = 1'b1;
    end

    // coincidence units: channel variables plus the neutron monitor bistables
    genvar gi;
    generate
        for (gi = 0; gi < `TV_NUNIT; gi++)
        begin : g_unit
            if (gi < `TV_NVAR)
            begin : g_var
                assign unit_trip[gi] = ~sync2_q.var_ok[gi]
                    | ((test_q[`TV_TEST_VAR_HI:`TV_TEST_VAR_LO] == 4'(gi)) ? inj_mask : '0);
            end
            else
            begin : g_nm
                assign unit_trip[gi] = ~sync2_q.nm_ok;
            end
            vote_count u_vote
            (
                .trip (unit_trip[gi]),
                .mask (snsr_byp_q),
                .vote (unit_vote[gi])
            );
            assign unit_part[gi] = |(unit_trip[gi] & ~snsr_byp_q);
        end
    endgenerate

    // own coincidence unit bypassed: the other divisions still carry automatic scram
    assign auto_act = (|unit_vote) && !cu_byp_q[DIV_ID];
    assign man_act  = (!sync2_q.man_ok_a && !sync2_q.man_ok_b) || !sync2_q.mode_run_ok;

    // completion delay, counted from the trip; the count is taken as finished only
    // once the trip conditions themselves have gone
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            dly_q <= '0;
        else if (seal_q == trip_voter_pkg::ST_NORMAL)
            dly_q <= '0;
        else if (dly_q < RESET_DELAY_CYC)
            dly_q <= dly_q + 32'h1;
    end

    assign dly_done   = (dly_q >= RESET_DELAY_CYC) && !auto_act && !man_act;
    assign reset_req  = sync2_q.reset_sw && !reset_sw_q;
    assign reset_take = (seal_q == trip_voter_pkg::ST_PERMIT) && reset_req;

    // seal-in sequence: a trip holds until the delay has run and the operator resets
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            seal_q <= trip_voter_pkg::ST_TRIPPED;
        else
        begin
            case (seal_q)
                trip_voter_pkg::ST_NORMAL:
                    if (auto_act || man_act)
                        seal_q <= trip_voter_pkg::ST_TRIPPED;
                trip_voter_pkg::ST_TRIPPED:
                    if (dly_done)
                        seal_q <= trip_voter_pkg::ST_PERMIT;
                trip_voter_pkg::ST_PERMIT:
                    if (auto_act || man_act)
                        seal_q <= trip_voter_pkg::ST_TRIPPED;
                    else if (reset_req)
                        seal_q <= trip_voter_pkg::ST_NORMAL;
                default:
                    seal_q <= trip_voter_pkg::ST_TRIPPED;
            endcase
        end
    end

    // separate latches show which trip path caused the seal-in
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            auto_q <= 1'b1;
            man_q  <= 1'b1;
        end
        else
        begin
            if (auto_act)
                auto_q <= 1'b1;
            else if (reset_take)
                auto_q <= 1'b0;
            if (man_act)
                man_q <= 1'b1;
            else if (reset_take)
                man_q <= 1'b0;
        end
    end

    assign div_trip = (seal_q != trip_voter_pkg::ST_NORMAL) || auto_act || man_act
                      || test_q[`TV_TEST_OUT];

    // two arrangements of the division states, each voted 2oo4
    vote_count u_scram_a
    (
        .trip (~sync2_q.div_ok_a),
        .mask (4'h0),
        .vote (scram_a)
    );
    vote_count u_scram_b
    (
        .trip (~sync2_q.div_ok_b),
        .mask (4'h0),
        .vote (scram_b)
    );

    assign full_scram = scram_a && scram_b;

    // drives: load drive and backup coil de-energise to trip, so a dead output reads as trip; air dump and rod run-in energise on full scram
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            drives_q <= '0;
        else
        begin
            drives_q.load_drive_on  <= !div_trip;
            drives_q.backup_coil_on <= !div_trip;
            drives_q.air_dump_on    <= full_scram;
            drives_q.rod_runin      <= full_scram;
            drives_q.reset_permit   <= (seal_q == trip_voter_pkg::ST_PERMIT);
        end
    end

    assign drives = drives_q;

    // events and sticky status; a set in the clear cycle wins
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            auto_prev_q <= 1'b0;
            man_prev_q  <= 1'b0;
        end
        else
        begin
            auto_prev_q <= auto_act;
            man_prev_q  <= man_act;
        end
    end

    always_comb
    begin
        evt                  = '0;
        evt[`TV_EVT_AUTO]    = auto_act && !auto_prev_q;
        evt[`TV_EVT_MANUAL]  = man_act && !man_prev_q;
        evt[`TV_EVT_REFUSED] = refused;
        evt[`TV_EVT_RESET]   = reset_take;
    end

    assign clr_wr = wr && (addr == `TV_REG_CLEAR);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            stat_q <= '0;
        else if (clr_wr)
            stat_q <= (stat_q & ~wdata[`TV_NEVT-1:0]) | evt;
        else
            stat_q <= stat_q | evt;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            en_q <= '0;
        else if (wr && addr == `TV_REG_ENABLE)
            en_q <= wdata[`TV_NEVT-1:0];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            test_q <= '0;
        else if (wr && addr == `TV_REG_TEST)
            test_q <= wdata[7:0];
    end

    assign irq = |(stat_q & en_q);

    // read data stands in the cycle after the read strobe only
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdata <= '0;
        else if (!rd)
            rdata <= '0;
        else
        begin
            case (addr)
                `TV_REG_STATUS:  rdata <= {28'h0, stat_q};
                `TV_REG_ENABLE:  rdata <= {28'h0, en_q};
                `TV_REG_STATE:   rdata <= {16'h0, cu_byp_q, snsr_byp_q, 1'b0, full_scram,
                                           seal_q, 1'b0, auto_q, man_q, div_trip};
                `TV_REG_TEST:    rdata <= {24'h0, test_q};
                `TV_REG_PARTIAL: rdata <= {7'h0, unit_vote, 7'h0, unit_part};
                default:         rdata <= '0;
            endcase
        end
    end
endmodule

// *** sim/field_model.sv ***
// field side of one division: channel trip modules, bistables and operator switches
// assumes cmd uses 1 = trip or switch operated on every ok line, unplug = cut cable
`timescale 1ns/1ps

module field_model
(
    // wanted field condition and cable fault
    input  wire trip_voter_pkg::pins_t cmd,
    input  wire logic                  unplug,
    // pin levels seen by the voter
    output trip_voter_pkg::pins_t      pins
);
    localparam int unsigned OKW = $bits(trip_voter_pkg::pins_t) - 9;

    // ok lines are active high, so a dead cable reads as trip and as no bypass
    assign pins = unplug ? '0 : (cmd ^ {{OKW{1'b1}}, 9'h000});
endmodule

// *** sim/division_trip_voter_monitor.sv ***
// port checker of the division trip voter
// assumes pins held steady several cycles per step, as the bench does
`timescale 1ns/1ps
`include "trip_voter_map.svh"

module division_trip_voter_monitor
(
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  rst,
    // register port
    input wire logic                  rd,
    input wire logic [31:0]           rdata,
    // field and drives
    input wire trip_voter_pkg::pins_t pins,
    input wire trip_voter_pkg::drives_t drives,
    input wire logic                  scram_a,
    input wire logic                  scram_b
);
    logic [1:0] up_q;
    logic       any_two;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // the synchronisers need three edges before pins and scram line up
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;

    always_comb
    begin
        any_two = ($countones(~pins.nm_ok) >= 2);
        for (int v = 0; v < `TV_NVAR; v++)
            if ($countones(~pins.var_ok[v]) >= 2)
                any_two = 1'b1;
    end

    sequence s_no_byp;
        pins.snsr_byp_req == 4'h0 && pins.cu_byp_req == 4'h0 &&
        $past(pins.snsr_byp_req, 3) == 4'h0 && $past(pins.cu_byp_req, 3) == 4'h0;
    endsequence
    sequence s_fall;
        $fell(drives.load_drive_on);
    endsequence

    property p_rdata_idle;
        !$past(rd) |-> rdata == 32'h0;
    endproperty
    property p_auto;
        any_two and s_no_byp |-> ##[1:4] !drives.load_drive_on;
    endproperty
    property p_manual;
        (!pins.man_ok_a && !pins.man_ok_b) || !pins.mode_run_ok |-> ##[1:4] !drives.load_drive_on;
    endproperty
    property p_scram;
        up_q == 2'h3 |-> scram_a == ($countones(~$past(pins.div_ok_a, 2)) >= 2) &&
                         scram_b == ($countones(~$past(pins.div_ok_b, 2)) >= 2);
    endproperty
    property p_seal;
        s_fall |-> (!drives.load_drive_on)[*8];
    endproperty
    property p_permit_wait;
        s_fall |-> (!drives.reset_permit)[*8];
    endproperty
    property p_backup;
        drives.backup_coil_on == drives.load_drive_on;
    endproperty
    property p_dump_runin;
        drives.air_dump_on == drives.rod_runin;
    endproperty
    property p_dump_full;
        (!scram_a || !scram_b)[*2] |-> !drives.air_dump_on;
    endproperty
    property p_reset_clear;
        $rose(pins.reset_sw) && drives.reset_permit |-> ##[2:5] drives.load_drive_on;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
    a_auto: assert property (p_auto) else $error("no automatic trip");
    a_manual: assert property (p_manual) else $error("no manual trip");
    a_scram: assert property (p_scram) else $error("scram vote wrong");
    a_seal: assert property (p_seal) else $error("trip not sealed");
    a_permit_wait: assert property (p_permit_wait) else $error("early permit");
    a_backup: assert property (p_backup) else $error("backup coil wrong");
    a_dump_runin: assert property (p_dump_runin) else $error("run-in wrong");
    a_dump_full: assert property (p_dump_full) else $error("dump without scram");
    a_reset_clear: assert property (p_reset_clear) else $error("reset ignored");
endmodule

bind division_trip_voter division_trip_voter_monitor i_monitor
(
    .mclk,
    .rst,
    .rd,
    .rdata,
    .pins,
    .drives,
    .scram_a,
    .scram_b
);

// *** sim/division_trip_voter_bench.sv ***
// self-checking bench of the division trip voter, field model on the pins
// assumes RESET_DELAY_CYC shortened to 16 cycles
`timescale 1ns/1ps
`include "trip_voter_map.svh"

module division_trip_voter_bench;
    logic                    mclk = 1'b0;
    logic                    rst = 1'b1;
    logic [`TV_ADDR_W-1:0]   addr = '0;
    logic [31:0]             wdata = '0;
    logic                    wr = 1'b0;
    logic                    rd = 1'b0;
    logic [31:0]             rdata;
    logic                    irq;
    logic                    scram_a;
    logic                    scram_b;
    logic                    unplug = 1'b0;
    trip_voter_pkg::pins_t   cmd = '0;
    trip_voter_pkg::pins_t   c;
    trip_voter_pkg::pins_t   pins;
    trip_voter_pkg::drives_t drives;
    int                      err_total = 0;
    int                      comparisons = 0;
    int                      cycles = 0;

    always #25 mclk = ~mclk;

    division_trip_voter #(.DIV_ID(0), .RESET_DELAY_CYC(16)) i_division_trip_voter
    (
        .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .pins, .drives, .scram_a, .scram_b
    );
    field_model i_field_model (.cmd, .unplug, .pins);

    task automatic conclude();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic put();
        @(posedge mclk);
        cmd <= c;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask

    // inputs healthy, wait out the completion delay, then press reset
    task automatic do_reset();
        c = '0;
        put();
        cyc(30);
        c.reset_sw = 1'b1;
        put();
        cyc(4);
        c.reset_sw = 1'b0;
        put();
        cyc(6);
        chk(32'(drives), 32'h18);
        wr_reg(`TV_REG_CLEAR, 32'hf);
    endtask

    initial
    begin
        c = '0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // power-up reads every input as trip until the synchronisers fill, so the dump
        // output pulses for two edges; look once that has passed
        cyc(3);
        chk(32'(drives), 32'h0);
        c.reset_sw = 1'b1;
        put();
        cyc(4);
        c.reset_sw = 1'b0;
        put();
        cyc(2);
        chk(drives.load_drive_on, 0);
        cyc(24);
        rd_reg(`TV_REG_STATE, 32'h20, 32'h30);
        chk(drives.reset_permit, 1);
        do_reset();
        wr_reg(`TV_REG_ENABLE, 32'hf);
        wr_reg(`TV_REG_STATE, 32'hffff);
        rd_reg(`TV_REG_ENABLE, 32'hf, 32'hffffffff);
        rd_reg(`TV_REG_STATE, 32'h0, 32'hffff);
        rd_reg(8'h20, 32'h0, 32'hffffffff);
        for (int u = 0; u < 9; u++)
        begin
            if (u < 8)
                c.var_ok[u][u % 4] = 1'b1;
            else
                c.nm_ok[0] = 1'b1;
            put();
            cyc(6);
            chk(drives.load_drive_on, 1);
            rd_reg(`TV_REG_PARTIAL, 32'h1 << u, 32'h1ff);
            if (u < 8)
                c.var_ok[u][(u + 1) % 4] = 1'b1;
            else
                c.nm_ok[1] = 1'b1;
            put();
            cyc(6);
            chk(drives.load_drive_on, 0);
            rd_reg(`TV_REG_STATUS, 32'h1, 32'h1);
            chk(irq, 1);
            do_reset();
        end
        c.snsr_byp_req = 4'h1;
        put();
        cyc(4);
        c.snsr_byp_req = 4'h3;
        put();
        cyc(4);
        rd_reg(`TV_REG_STATE, 32'h100, 32'hf00);
        rd_reg(`TV_REG_STATUS, 32'h4, 32'h4);
        c.var_ok[0] = 4'h3;
        put();
        cyc(6);
        chk(drives.load_drive_on, 1);
        c.var_ok[0] = 4'h7;
        put();
        cyc(6);
        chk(drives.load_drive_on, 0);
        do_reset();
        // the bypass must be held before the coincidence appears, or the first vote seals in
        c.cu_byp_req = 4'h1;
        put();
        cyc(4);
        c.var_ok[2] = 4'h6;
        c.man_ok_a = 1'b1;
        put();
        cyc(6);
        chk(drives.load_drive_on, 1);
        rd_reg(`TV_REG_STATE, 32'h1000, 32'hf000);
        c.man_ok_b = 1'b1;
        put();
        cyc(6);
        chk(drives.load_drive_on, 0);
        rd_reg(`TV_REG_STATE, 32'h2, 32'h2);
        do_reset();
        c.mode_run_ok = 1'b1;
        put();
        cyc(6);
        chk(drives.load_drive_on, 0);
        do_reset();
        wr_reg(`TV_REG_TEST, 32'h15);
        cyc(4);
        rd_reg(`TV_REG_PARTIAL, 32'h2, 32'h20002);
        chk(drives.load_drive_on, 1);
        wr_reg(`TV_REG_TEST, 32'h2);
        cyc(10);
        chk(drives.load_drive_on, 0);
        wr_reg(`TV_REG_TEST, 32'h0);
        cyc(4);
        chk(drives.load_drive_on, 1);
        c.div_ok_a = 4'h1;
        put();
        cyc(4);
        chk(scram_a, 0);
        c.div_ok_a = 4'h9;
        put();
        cyc(4);
        chk({scram_a, scram_b, drives.air_dump_on}, 3'h4);
        c.div_ok_b = 4'h6;
        put();
        cyc(4);
        chk({scram_b, drives.air_dump_on, drives.rod_runin}, 3'h7);
        c = '0;
        put();
        cyc(5);
        chk(drives.air_dump_on, 0);
        do_reset();
        wr_reg(`TV_REG_ENABLE, 32'h0);
        @(posedge mclk);
        unplug <= 1'b1;
        cyc(6);
        chk({drives.load_drive_on, irq}, 2'h0);
        rd_reg(`TV_REG_STATUS, 32'h3, 32'h3);
        wr_reg(`TV_REG_ENABLE, 32'hf);
        cyc(1);
        chk(irq, 1);
        wr_reg(`TV_REG_CLEAR, 32'hf);
        cyc(1);
        chk(irq, 0);
        @(posedge mclk);
        unplug <= 1'b0;
        do_reset();
        conclude();
    end
endmodule
